/* uart_fmt_defs.svh */
// Register offsets, field positions, reset values and codes for the UART format block.
`ifndef UART_FMT_DEFS_SVH
`define UART_FMT_DEFS_SVH
`define OFF_LINE_CTL  6'h00
`define OFF_FIFO_CTL  6'h04
`define OFF_IRQ_STAT  6'h08
`define OFF_ENH_FEAT  6'h0c
`define OFF_RX_LVL    6'h10
`define OFF_TX_LVL    6'h14
`define OFF_FLOW_LO   6'h18
`define OFF_FLOW_HI   6'h1c
`define OFF_TRIG_STAT 6'h20
`define RST_REG8      8'h00
`define RST_IRQ_STAT  8'h01
`define LC_DIV_BIT    7
`define LC_BRK_BIT    6
`define FC_EN_BIT     0
`define EF_XOFF_BIT   4
`define RX_TRIG_0     8'h08
`define RX_TRIG_1     8'h10
`define RX_TRIG_2     8'h18
`define RX_TRIG_3     8'h1c
`define TX_TRIG_0     8'h10
`define TX_TRIG_1     8'h08
`define TX_TRIG_2     8'h18
`define TX_TRIG_3     8'h1e
`define CODE_NONE     6'h01
`define CODE_LINE     6'h06
`define CODE_RXDATA   6'h04
`define CODE_RXTMO    6'h0c
`define CODE_TXEMPTY  6'h02
`define CODE_MODEM    6'h00
`define CODE_XOFF     6'h10
`define CODE_CTSRTS   6'h20
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

/* uart_fmt_pkg.sv */
// Types shared by the UART interrupt priority and line format block.
package uart_fmt_pkg;
  typedef enum logic [7:0] {
    SRC_NONE    = 8'h01,
    SRC_LINE    = 8'h02,
    SRC_RXDATA  = 8'h04,
    SRC_RXTMO   = 8'h08,
    SRC_TXEMPTY = 8'h10,
    SRC_MODEM   = 8'h20,
    SRC_XOFF    = 8'h40,
    SRC_CTSRTS  = 8'h80
  } src_e;
  typedef enum logic [4:0] {
    PAR_NONE   = 5'h01,
    PAR_ODD    = 5'h02,
    PAR_EVEN   = 5'h04,
    PAR_FORCE1 = 5'h08,
    PAR_FORCE0 = 5'h10
  } parity_e;
  typedef struct packed {
    logic line_err;
    logic rx_data;
    logic rx_timeout;
    logic tx_empty;
    logic modem_change;
    logic xoff_match;
    logic xon_match;
    logic special_char;
    logic cts_rts_change;
  } irq_src_s;
  typedef struct packed {
    logic [3:0] data_bits;
    logic [2:0] stop_halves;
    parity_e    parity;
    logic       brk;
    logic       div_access;
    logic       fifo_en;
  } line_fmt_s;
endpackage

/* uart_fmt.sv */
// Interrupt priority encoder and line format controls behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "uart_fmt_defs.svh"
// How it works
// - Fifo_control bits 7:6 pick receive trigger 8, 16, 24 or 28 bytes.
// - Fifo_control bits 5:4 pick transmit trigger 16, 8, 24 or 30 bytes.
// - Any nonzero level or flow threshold register makes both triggers come from levels.
// - Status read shows only the latched source; the highest still pending appears after servicing.
// - A pending unserviced source blocks every other source from the status code.
// - Receiver line status error is top priority, code 000110.
// - Received data available is priority two, code 000100.
// - Receive time-out is priority two, code 001100.
// - Transmit holding empty is priority three 000010; modem change priority four 000000.
// - Xoff or special character detect is priority five, code 010000.
// - CTS or RTS change is lowest priority six, code 100000.
// - Bits 5:4 work only with enhanced bit 4; Xoff flag holds until Xon.
// - Status bits 7:6 read ones with FIFOs enabled, zeros otherwise.
// - Status bit 0 is zero while pending, one when idle and after reset.
// - Line_control bit 7 drives the divisor latch access output; resets to zero.
// - Line_control bit 6 holds transmit output low until software clears it.
// - Line_control bits 5:3 choose none, odd, even, forced-one or forced-zero parity.
// - Bit 2 clear gives one stop bit, else 1.5 for 5-bit, 2 otherwise.
// - Line_control bits 1:0 give 5, 6, 7 or 8 data bits.
// - Fifo_control bit 0 enables both FIFOs; zero after reset means non-FIFO mode.
module uart_fmt (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [5:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [5:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire uart_fmt_pkg::irq_src_s irq_src,
  input  wire logic                   tx_serial_in,
  output logic                        tx_serial_out,
  output uart_fmt_pkg::line_fmt_s     line_fmt,
  output logic [7:0]                  rx_trigger,
  output logic [7:0]                  tx_trigger,
  output logic                        irq_pending,
  output logic                        xoff_held
);

  typedef struct packed {
    logic [7:0]              line_ctl;
    logic [7:0]              fifo_ctl;
    logic [7:0]              enh_feat;
    logic [7:0]              rx_lvl;
    logic [7:0]              tx_lvl;
    logic [7:0]              flow_lo;
    logic [7:0]              flow_hi;
    logic [7:0]              irq_stat;
    logic                    pend;
    uart_fmt_pkg::src_e      cur;
    logic                    xoff;
    logic                    aw_got;
    logic [5:0]              waddr;
    logic                    w_got;
    logic [7:0]              wbyte;
    logic                    wlane0;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    tx;
    logic [7:0]              rx_trig;
    logic [7:0]              tx_trig;
    uart_fmt_pkg::line_fmt_s fmt;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  function automatic logic [5:0] src_code(input uart_fmt_pkg::src_e src);
    case (src)
      uart_fmt_pkg::SRC_LINE:    src_code = `CODE_LINE;
      uart_fmt_pkg::SRC_RXDATA:  src_code = `CODE_RXDATA;
      uart_fmt_pkg::SRC_RXTMO:   src_code = `CODE_RXTMO;
      uart_fmt_pkg::SRC_TXEMPTY: src_code = `CODE_TXEMPTY;
      uart_fmt_pkg::SRC_MODEM:   src_code = `CODE_MODEM;
      uart_fmt_pkg::SRC_XOFF:    src_code = `CODE_XOFF;
      uart_fmt_pkg::SRC_CTSRTS:  src_code = `CODE_CTSRTS;
      default:                   src_code = `CODE_NONE;
    endcase
  endfunction

  logic [7:0] act;
  logic       ext_en;
  logic       wr_go;
  logic [7:0] fc_new;
  logic [7:0] rx_pick;
  logic [7:0] tx_pick;
  logic [5:0] word_addr;
  logic [7:0] rd_byte;
  logic       rd_hit;

  // Both tables see the byte being written, so the triggers move in the edge the write lands.
  trig_pick #(
    .LVL0 (`RX_TRIG_0),
    .LVL1 (`RX_TRIG_1),
    .LVL2 (`RX_TRIG_2),
    .LVL3 (`RX_TRIG_3)
  ) trig_pick_rx (
    .code  (fc_new[7:6]),
    .level (rx_pick)
  );

  trig_pick #(
    .LVL0 (`TX_TRIG_0),
    .LVL1 (`TX_TRIG_1),
    .LVL2 (`TX_TRIG_2),
    .LVL3 (`TX_TRIG_3)
  ) trig_pick_tx (
    .code  (fc_new[5:4]),
    .level (tx_pick)
  );

  always_comb begin
    ext_en = s_r.enh_feat[`EF_XOFF_BIT];
    // The level 5 and 6 sources exist only while the enhanced bit is set.
    act = {ext_en & irq_src.cts_rts_change,
           ext_en & (s_r.xoff | irq_src.special_char),
           irq_src.modem_change,
           irq_src.tx_empty,
           irq_src.rx_timeout,
           irq_src.rx_data,
           irq_src.line_err,
           1'b0};
    // Address and data may come in either order; the write lands once both are held.
    wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    fc_new = s_r.fifo_ctl;
    if (wr_go && s_r.wlane0 && (s_r.waddr == `OFF_FIFO_CTL)) begin
      fc_new = s_r.wbyte;
    end
    word_addr = {s_axi_araddr[5:2], 2'b00};
    rd_hit = 1'b1;
    case (word_addr)
      `OFF_LINE_CTL:  rd_byte = s_r.line_ctl;
      `OFF_FIFO_CTL:  rd_byte = s_r.fifo_ctl;
      `OFF_IRQ_STAT:  rd_byte = s_r.irq_stat;
      `OFF_ENH_FEAT:  rd_byte = s_r.enh_feat;
      `OFF_RX_LVL:    rd_byte = s_r.rx_lvl;
      `OFF_TX_LVL:    rd_byte = s_r.tx_lvl;
      `OFF_FLOW_LO:   rd_byte = s_r.flow_lo;
      `OFF_FLOW_HI:   rd_byte = s_r.flow_hi;
      `OFF_TRIG_STAT: rd_byte = s_r.rx_trig;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // Write address and data are captured independently, in either order.
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = {s_axi_awaddr[5:2], 2'b00};
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wbyte = s_axi_wdata[7:0];
      s_nxt.wlane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `RESP_OKAY;
      case (s_r.waddr)
        `OFF_LINE_CTL: if (s_r.wlane0) s_nxt.line_ctl = s_r.wbyte;
        `OFF_FIFO_CTL: if (s_r.wlane0) s_nxt.fifo_ctl = s_r.wbyte;
        `OFF_ENH_FEAT: if (s_r.wlane0) s_nxt.enh_feat = s_r.wbyte;
        `OFF_RX_LVL:   if (s_r.wlane0) s_nxt.rx_lvl = s_r.wbyte;
        `OFF_TX_LVL:   if (s_r.wlane0) s_nxt.tx_lvl = s_r.wbyte;
        `OFF_FLOW_LO:  if (s_r.wlane0) s_nxt.flow_lo = s_r.wbyte;
        `OFF_FLOW_HI:  if (s_r.wlane0) s_nxt.flow_hi = s_r.wbyte;
        `OFF_IRQ_STAT, `OFF_TRIG_STAT: s_nxt.bresp = `RESP_OKAY;
        default:       s_nxt.bresp = `RESP_SLVERR;
      endcase
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (word_addr == `OFF_TRIG_STAT) begin
        s_nxt.rdata = {16'h0000, s_r.tx_trig, s_r.rx_trig};
      end else begin
        s_nxt.rdata = {24'h000000, rd_byte};
      end
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Set beats clear, so an Xoff arriving with an Xon is kept.
    if (irq_src.xon_match) s_nxt.xoff = 1'b0;
    if (irq_src.xoff_match && ext_en) s_nxt.xoff = 1'b1;

    // The latched source is held until its own cause goes away, so a
    // handler never sees the code change under it mid-service.
    if ((s_r.cur & act) == 8'h00) begin
      if (act[1])      s_nxt.cur = uart_fmt_pkg::SRC_LINE;
      else if (act[2]) s_nxt.cur = uart_fmt_pkg::SRC_RXDATA;
      else if (act[3]) s_nxt.cur = uart_fmt_pkg::SRC_RXTMO;
      else if (act[4]) s_nxt.cur = uart_fmt_pkg::SRC_TXEMPTY;
      else if (act[5]) s_nxt.cur = uart_fmt_pkg::SRC_MODEM;
      else if (act[6]) s_nxt.cur = uart_fmt_pkg::SRC_XOFF;
      else if (act[7]) s_nxt.cur = uart_fmt_pkg::SRC_CTSRTS;
      else             s_nxt.cur = uart_fmt_pkg::SRC_NONE;
    end
    s_nxt.irq_stat = {s_nxt.fifo_ctl[`FC_EN_BIT] ? 2'b11 : 2'b00,
                      src_code(s_nxt.cur)};
    // The pin has its own flop rather than an inverter behind the status byte.
    s_nxt.pend = !s_nxt.irq_stat[0];

    s_nxt.rx_trig = rx_pick;
    s_nxt.tx_trig = tx_pick;
    // The override looks at the new level values so it lands with the write that sets them.
    if (|{s_nxt.rx_lvl, s_nxt.tx_lvl, s_nxt.flow_lo, s_nxt.flow_hi}) begin
      s_nxt.rx_trig = s_nxt.rx_lvl;
      s_nxt.tx_trig = s_nxt.tx_lvl;
    end

    s_nxt.fmt.data_bits = 4'd5 + {2'b00, s_nxt.line_ctl[1:0]};
    if (!s_nxt.line_ctl[2]) begin
      s_nxt.fmt.stop_halves = 3'd2;
    end else if (s_nxt.line_ctl[1:0] == 2'b00) begin
      s_nxt.fmt.stop_halves = 3'd3;
    end else begin
      s_nxt.fmt.stop_halves = 3'd4;
    end
    case (s_nxt.line_ctl[5:3])
      3'b001:  s_nxt.fmt.parity = uart_fmt_pkg::PAR_ODD;
      3'b011:  s_nxt.fmt.parity = uart_fmt_pkg::PAR_EVEN;
      3'b101:  s_nxt.fmt.parity = uart_fmt_pkg::PAR_FORCE1;
      3'b111:  s_nxt.fmt.parity = uart_fmt_pkg::PAR_FORCE0;
      default: s_nxt.fmt.parity = uart_fmt_pkg::PAR_NONE;
    endcase
    s_nxt.fmt.brk = s_nxt.line_ctl[`LC_BRK_BIT];
    s_nxt.fmt.div_access = s_nxt.line_ctl[`LC_DIV_BIT];
    s_nxt.fmt.fifo_en = s_nxt.fifo_ctl[`FC_EN_BIT];
    // Break overrides the serializer, whatever state it is in.
    s_nxt.tx = s_nxt.line_ctl[`LC_BRK_BIT] ? 1'b0 : tx_serial_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.line_ctl <= `RST_REG8;
      s_r.fifo_ctl <= `RST_REG8;
      s_r.enh_feat <= `RST_REG8;
      s_r.rx_lvl <= `RST_REG8;
      s_r.tx_lvl <= `RST_REG8;
      s_r.flow_lo <= `RST_REG8;
      s_r.flow_hi <= `RST_REG8;
      s_r.irq_stat <= `RST_IRQ_STAT;
      s_r.pend <= 1'b0;
      s_r.cur <= uart_fmt_pkg::SRC_NONE;
      s_r.tx <= 1'b1;
      s_r.rx_trig <= `RX_TRIG_0;
      s_r.tx_trig <= `TX_TRIG_0;
      s_r.fmt.data_bits <= 4'd5;
      s_r.fmt.stop_halves <= 3'd2;
      s_r.fmt.parity <= uart_fmt_pkg::PAR_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign tx_serial_out = s_r.tx;
  assign line_fmt = s_r.fmt;
  assign rx_trigger = s_r.rx_trig;
  assign tx_trigger = s_r.tx_trig;
  assign irq_pending = s_r.pend;
  assign xoff_held = s_r.xoff;

endmodule

// Picks one of four trigger levels by a two-bit code.
module trig_pick #(
  parameter logic [7:0] LVL0 = `RX_TRIG_0,
  parameter logic [7:0] LVL1 = `RX_TRIG_1,
  parameter logic [7:0] LVL2 = `RX_TRIG_2,
  parameter logic [7:0] LVL3 = `RX_TRIG_3
) (
  input  wire logic [1:0] code,
  output logic      [7:0] level
);

  always_comb begin
    case (code)
      2'b00:   level = LVL0;
      2'b01:   level = LVL1;
      2'b10:   level = LVL2;
      default: level = LVL3;
    endcase
  end

endmodule

/* uart_fmt_chk.sv */
// Concurrent checks on the ports of the UART format block.
`timescale 1ns/1ps
module uart_fmt_chk (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_bvalid,
  input wire uart_fmt_pkg::irq_src_s  irq_src,
  input wire logic                    tx_serial_in,
  input wire logic                    tx_serial_out,
  input wire uart_fmt_pkg::line_fmt_s line_fmt,
  input wire logic [7:0]              rx_trigger,
  input wire logic [7:0]              tx_trigger,
  input wire logic                    irq_pending,
  input wire logic                    xoff_held
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_brk;
    $past(line_fmt.brk) && line_fmt.brk |-> !tx_serial_out;
  endproperty
  a_brk: assert property (p_brk) else $error("line not held low in break");
  property p_follow;
    !line_fmt.brk && $past(aresetn)
      |-> tx_serial_out == $past(tx_serial_in);
  endproperty
  a_follow: assert property (p_follow) else $error("line does not follow serializer");
  property p_pend_on;
    $past(irq_src.line_err) && $past(aresetn) |-> irq_pending;
  endproperty
  a_pend_on: assert property (p_pend_on) else $error("line error not pending");
  property p_pend_off;
    $past(irq_src) == '0 && !$past(xoff_held) |-> !irq_pending;
  endproperty
  a_pend_off: assert property (p_pend_off) else $error("pending with no source");
  // Steady sources must never let a latched interrupt lapse.
  property p_hold;
    $past(irq_pending) && $past(irq_src) == $past(irq_src, 2) |-> irq_pending;
  endproperty
  a_hold: assert property (p_hold) else $error("pending dropped with sources steady");
  property p_xoff;
    $past(xoff_held) && !$past(irq_src.xon_match) |-> xoff_held;
  endproperty
  a_xoff: assert property (p_xoff) else $error("xoff flag cleared without xon");
  property p_cfg;
    !$rose(s_axi_bvalid) && $past(aresetn)
      |-> $stable(line_fmt) && $stable(rx_trigger) && $stable(tx_trigger);
  endproperty
  a_cfg: assert property (p_cfg) else $error("format changed outside a write");
  property p_stop;
    (line_fmt.data_bits == 4'h5) ? line_fmt.stop_halves inside {3'h2, 3'h3}
                                 : line_fmt.stop_halves inside {3'h2, 3'h4};
  endproperty
  a_stop: assert property (p_stop) else $error("stop length illegal for word");
  property p_fmt;
    $onehot(line_fmt.parity) && line_fmt.data_bits inside {[4'h5:4'h8]};
  endproperty
  a_fmt: assert property (p_fmt) else $error("parity or word length illegal");
endmodule
bind uart_fmt uart_fmt_chk uart_fmt_chk_inst (.aclk, .aresetn, .s_axi_bvalid, .irq_src,
  .tx_serial_in, .tx_serial_out, .line_fmt, .rx_trigger, .tx_trigger, .irq_pending, .xoff_held);

/* line_model.sv */
// Line-side monitor of the remote receiver that flags a held break.
`timescale 1ns/1ps
module line_model #(
  parameter int BRK_MIN = 8
) (
  input  wire logic aclk,
  input  wire logic line,
  output logic      break_seen
);
  int low_cnt = 0;
  // A break is a low line held longer than a character; short lows are data.
  always @(posedge aclk) begin
    low_cnt <= line ? 0 : low_cnt + 1;
    break_seen <= !line && (low_cnt >= BRK_MIN);
  end
endmodule

/* uart_fmt_tb_top.sv */
// Self-checking bench for the UART interrupt priority and line format block.
`timescale 1ns/1ps
`include "uart_fmt_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module uart_fmt_tb_top;
  logic                    aclk;
  logic                    aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                    arvalid = 1'b0, rready = 1'b0, tx_in = 1'b1;
  logic                    awready, wready, bvalid, arready, rvalid, tx_out, pend, xheld, brk;
  logic [5:0]              awaddr = 6'h00, araddr = 6'h00;
  logic [31:0]             wdata = 32'h0, rdata;
  logic [3:0]              wstrb = 4'hf;
  logic [1:0]              bresp, rresp;
  logic [7:0]              rx_trig, tx_trig;
  uart_fmt_pkg::irq_src_s  src = '0;
  uart_fmt_pkg::line_fmt_s fmt;
  int                      err_count = 0, comparisons = 0;
  logic [7:0]              rxt [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
  logic [7:0]              txt [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
  logic [8:0]              srcv [10] = '{9'h1f3, 9'h0f3, 9'h073, 9'h033, 9'h013, 9'h003,
                                         9'h001, 9'h021, 9'h020, 9'h000};
  logic [5:0]              code [10] = '{6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20,
                                         6'h20, 6'h02, 6'h01};
  uart_fmt uart_fmt_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_src(src), .tx_serial_in(tx_in), .tx_serial_out(tx_out),
    .line_fmt(fmt), .rx_trigger(rx_trig), .tx_trigger(tx_trig), .irq_pending(pend),
    .xoff_held(xheld));
  line_model line_model_inst (.aclk(aclk), .line(tx_out), .break_seen(brk));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask
  function automatic uart_fmt_pkg::parity_e par_exp(input logic [2:0] p);
    if (!p[0]) return uart_fmt_pkg::PAR_NONE;
    if (!p[1]) return p[2] ? uart_fmt_pkg::PAR_FORCE1 : uart_fmt_pkg::PAR_ODD;
    return p[2] ? uart_fmt_pkg::PAR_FORCE0 : uart_fmt_pkg::PAR_EVEN;
  endfunction
  task automatic pulse(input logic [8:0] v, input logic e);
    src <= v;
    @(posedge aclk);
    src <= '0;
    repeat (4) @(posedge aclk);
    `CHK("xoff_held", e, xheld)
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_LINE_CTL, 32'h0, `RESP_OKAY);
    rd(`OFF_IRQ_STAT, 32'h01, `RESP_OKAY);
    rd(`OFF_TRIG_STAT, 32'h1008, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_FIFO_CTL, {i[1:0], 2'(3 - i), 4'h1}, `RESP_OKAY);
      `CHK("rx_trig", rxt[i], rx_trig)
      `CHK("tx_trig", txt[3 - i], tx_trig)
      `CHK("fifo_en", 1'b1, fmt.fifo_en)
    end
    rd(`OFF_TRIG_STAT, {16'h0, txt[0], rxt[3]}, `RESP_OKAY);
    wr(`OFF_RX_LVL, 8'h05, `RESP_OKAY);
    wr(`OFF_TX_LVL, 8'h07, `RESP_OKAY);
    `CHK("lvl", 16'h0705, {tx_trig, rx_trig})
    wr(`OFF_RX_LVL, 8'h00, `RESP_OKAY);
    wr(`OFF_TX_LVL, 8'h00, `RESP_OKAY);
    for (int a = `OFF_FLOW_LO; a <= `OFF_FLOW_HI; a += 4) begin
      wr(6'(a), 8'h03, `RESP_OKAY);
      `CHK("flow", 16'h0000, {tx_trig, rx_trig})
      wr(6'(a), 8'h00, `RESP_OKAY);
      `CHK("flow_off", {txt[0], rxt[3]}, {tx_trig, rx_trig})
    end
    for (int i = 0; i < 64; i++) begin
      wr(`OFF_LINE_CTL, {i[0], 1'b0, i[5:0]}, `RESP_OKAY);
      rd(`OFF_LINE_CTL, {24'h0, i[0], 1'b0, i[5:0]}, `RESP_OKAY);
      `CHK("bits", 4'(5 + i[1:0]), fmt.data_bits)
      `CHK("stop", !i[2] ? 3'h2 : (i[1:0] == 2'b00 ? 3'h3 : 3'h4), fmt.stop_halves)
      `CHK("parity", par_exp(i[5:3]), fmt.parity)
      `CHK("div", i[0], fmt.div_access)
    end
    wstrb <= 4'h0;
    wr(`OFF_LINE_CTL, 8'h00, `RESP_OKAY);
    wstrb <= 4'hf;
    rd(`OFF_LINE_CTL, 32'hbf, `RESP_OKAY);
    wr(`OFF_LINE_CTL, 8'h40, `RESP_OKAY);
    repeat (10) @(posedge aclk);
    `CHK("brk_line", 3'b101, {fmt.brk, tx_out, brk})
    wr(`OFF_LINE_CTL, 8'h03, `RESP_OKAY);
    tx_in <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("line_lo", 1'b0, tx_out)
    tx_in <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK("line_hi", 3'b010, {fmt.brk, tx_out, brk})
    wr(`OFF_ENH_FEAT, 8'h00, `RESP_OKAY);
    src <= 9'h003;
    repeat (2) @(posedge aclk);
    rd(`OFF_IRQ_STAT, 32'hc1, `RESP_OKAY);
    pulse(9'h008, 1'b0);
    wr(`OFF_ENH_FEAT, 8'h10, `RESP_OKAY);
    for (int k = 0; k < 10; k++) begin
      src <= srcv[k];
      repeat (2) @(posedge aclk);
      rd(`OFF_IRQ_STAT, {24'h0, 2'b11, code[k]}, `RESP_OKAY);
      `CHK("pending", code[k] != 6'h01, pend)
    end
    pulse(9'h008, 1'b1);
    pulse(9'h004, 1'b0);
    wr(`OFF_IRQ_STAT, 8'h00, `RESP_OKAY);
    rd(`OFF_IRQ_STAT, 32'hc1, `RESP_OKAY);
    wr(6'h24, 8'h5a, `RESP_SLVERR);
    rd(6'h24, 32'h0, `RESP_SLVERR);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run();
  end
endmodule
